// file: rtl/tex_pkg.sv
// constants shared by the trap and exception unit
package tex_pkg;

  // ---------------------------------------------------------------
  // status word layout and reset value
  // ---------------------------------------------------------------
  localparam logic [31:0] PSW_RST  = 32'h0000_0020;
  localparam int          ID_BIT   = 5;
  localparam int          EP_BIT   = 6;
  localparam int          NP_BIT   = 7;

  // ---------------------------------------------------------------
  // handler addresses and cause codes
  // ---------------------------------------------------------------
  localparam logic [31:0] TRAP_LO_VEC    = 32'h0000_0040;
  localparam logic [31:0] TRAP_HI_VEC    = 32'h0000_0050;
  localparam logic [31:0] DBG_VEC        = 32'h0000_0060;
  localparam int          TRAP_SEL_BIT   = 4;
  localparam logic [15:0] TRAP_CODE_BASE = 16'h0040;

  // ---------------------------------------------------------------
  // bad opcode fields
  // ---------------------------------------------------------------
  localparam int          OPC_LSB  = 5;
  localparam int          OPC_MSB  = 10;
  localparam int          SUB_LSB  = 23;
  localparam int          SUB_MSB  = 26;
  localparam int          SUB_BIT  = 16;
  localparam logic [3:0]  SUB_MIN  = 4'h7;

  // ---------------------------------------------------------------
  // register map (byte addresses) and bus answers
  // ---------------------------------------------------------------
  localparam int          ADDR_W      = 8;
  localparam logic [7:0]  REG_PSW     = 8'h00;
  localparam logic [7:0]  REG_EXC_PC  = 8'h04;
  localparam logic [7:0]  REG_EXC_PSW = 8'h08;
  localparam logic [7:0]  REG_CAUSE   = 8'h0c;
  localparam logic [7:0]  REG_NMI_PC  = 8'h10;
  localparam logic [7:0]  REG_NMI_PSW = 8'h14;
  localparam logic [7:0]  REG_DBG_PC  = 8'h18;
  localparam logic [7:0]  REG_DBG_PSW = 8'h1c;
  localparam logic [7:0]  REG_IN_SERVICE_PRIORITY    = 8'h20;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic [1:0]  RESP_DECERR = 2'h3;

endpackage

// file: rtl/tex_classify.sv
// instruction and in-service classifier for the trap unit
`timescale 1ns/100ps
module tex_classify
  import tex_pkg::*;
(
  input  wire logic [31:0] i_instr,
  input  wire logic [7:0]  i_in_service_priority,
  input  wire logic [2:0]  i_prio,
  output logic             o_bad_op,
  output logic [7:0]       o_top_onehot,
  output logic             o_prio_blocked
);

  logic [7:0] blk;

  // ---------------------------------------------------------------
  // reserved encodings raise the bad opcode trap
  // ---------------------------------------------------------------
  assign o_bad_op = (&i_instr[OPC_MSB:OPC_LSB])
                  & (i_instr[SUB_MSB:SUB_LSB] >= SUB_MIN)
                  & ~i_instr[SUB_BIT];

  // per level: lowest index is the highest priority
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_lvl
      if (g == 0) begin : g_first
        assign o_top_onehot[g] = i_in_service_priority[g];
      end else begin : g_rest
        assign o_top_onehot[g] = i_in_service_priority[g] & ~(|i_in_service_priority[g-1:0]);
      end
      // equal or higher level in service holds a new request back
      assign blk[g] = i_in_service_priority[g] & (3'(g) <= i_prio);
    end
  endgenerate

  assign o_prio_blocked = |blk;

endmodule

// file: rtl/tex_unit.sv
// trap, exception and interrupt-disable control with register slave
//
// Functional notes
// - reset status word to 00000020h, maskable interrupts refused
// - maskable requests taken only with disable clear
// - mask/enable/return/load instructions rewrite disable flag
// - non-maskable and exceptions ignore the disable flag
// - taking a maskable request sets disable flag
// - pending request taken once disable flag clears
// - trap instruction raises software exception unless bad opcode or debug break wins
// - exception saves pc, status, cause; sets flags
// - vector 00-0f to 40h, 10-1f to 50h
// - return with exception flag restores exception copies
// - every exception sets exception-in-progress flag
// - reserved opcode pattern raises bad opcode trap
// - bad opcode saves debug copies, jumps 60h
// - debug break always taken, same as bad opcode
// - debug return restores debug copies and resumes
// - debug copies reachable only inside debug window
// - return clears top in-service bit, not after nmi/exception
//
// Chosen here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
module tex_unit
  import tex_pkg::*;
(
  input  wire logic              i_clock,
  input  wire logic              i_rst_n,
  input  wire logic              i_instr_valid,
  input  wire logic [31:0]       i_instr,
  input  wire logic [31:0]       i_pc,
  input  wire logic              i_op_di,
  input  wire logic              i_op_ei,
  input  wire logic              i_op_return_from_interrupt_instr,
  input  wire logic              i_op_trap,
  input  wire logic [4:0]        i_trap_vec,
  input  wire logic              i_op_debug_break_instr,
  input  wire logic              i_op_debug_return_instr,
  input  wire logic              i_op_load_system_reg_instr_psw,
  input  wire logic [31:0]       i_load_system_reg_instr_data,
  input  wire logic              i_nmi_req,
  input  wire logic [31:0]       i_nmi_handler,
  input  wire logic [15:0]       i_nmi_code,
  input  wire logic              i_mi_req,
  input  wire logic [2:0]        i_mi_prio,
  input  wire logic [31:0]       i_mi_handler,
  input  wire logic [15:0]       i_mi_code,
  output logic                   o_pc_load,
  output logic [31:0]            o_pc_target,
  output logic                   o_nmi_ack,
  output logic                   o_mi_ack,
  output logic [31:0]            o_psw,
  output logic [7:0]             o_in_service_priority,
  output logic                   o_dbg_open,
  input  wire logic              i_awvalid,
  output logic                   o_awready,
  input  wire logic [ADDR_W-1:0] i_awaddr,
  input  wire logic              i_wvalid,
  output logic                   o_wready,
  input  wire logic [31:0]       i_wdata,
  input  wire logic [3:0]        i_wstrb,
  output logic                   o_bvalid,
  input  wire logic              i_bready,
  output logic [1:0]             o_bresp,
  input  wire logic              i_arvalid,
  output logic                   o_arready,
  input  wire logic [ADDR_W-1:0] i_araddr,
  output logic                   o_rvalid,
  input  wire logic              i_rready,
  output logic [31:0]            o_rdata,
  output logic [1:0]             o_rresp
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [31:0]       psw_r, psw_nxt;
  logic [31:0]       exc_pc_r, exc_psw_r, cause_r;
  logic [31:0]       nmi_pc_r, nmi_psw_r;
  logic [31:0]       dbg_pc_r, dbg_psw_r;
  logic [7:0]        in_service_priority_r;
  logic              dbg_open_r;
  logic              pc_load_r, nmi_ack_r, mi_ack_r;
  logic [31:0]       pc_target_r, pc_nxt;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0]       wdata_r;
  logic [3:0]        wstrb_r;
  logic              awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0]        bresp_r, rresp_r;
  logic [31:0]       rdata_r;

  logic        bad_op, prio_blocked;
  logic [7:0]  top_onehot;
  logic        ok_instr, take_dbg, take_trap, take_return_from_interrupt_instr, take_debug_return_instr;
  logic        take_nmi, take_mi, redirect, return_from_interrupt_instr_nmi, return_from_interrupt_instr_plain;
  logic        wr_fire, bus_psw_wr, wr_known;
  logic [31:0] trap_target, return_from_interrupt_instr_pc, return_from_interrupt_instr_psw, psw_wr_val, rd_val;
  logic [1:0]  rd_resp;

  tex_classify u_classify (
    .i_instr        (i_instr),
    .i_in_service_priority         (in_service_priority_r),
    .i_prio         (i_mi_prio),
    .o_bad_op       (bad_op),
    .o_top_onehot   (top_onehot),
    .o_prio_blocked (prio_blocked)
  );

  // ---------------------------------------------------------------
  // event selection
  // ---------------------------------------------------------------
  // an executing instruction owns the cycle; requests wait for a cycle without one
  assign ok_instr   = i_instr_valid & ~bad_op;
  assign take_dbg   = i_instr_valid & (bad_op | i_op_debug_break_instr);
  assign take_trap  = ok_instr & i_op_trap & ~i_op_debug_break_instr;
  assign take_return_from_interrupt_instr  = ok_instr & i_op_return_from_interrupt_instr;
  assign take_debug_return_instr = ok_instr & i_op_debug_return_instr;
  // level request; guard against re-taking while the ack is in flight
  assign take_nmi   = i_nmi_req & ~i_instr_valid & ~nmi_ack_r;
  assign take_mi    = i_mi_req & ~psw_r[ID_BIT] & ~i_instr_valid
                    & ~i_nmi_req & ~prio_blocked & ~mi_ack_r;
  assign redirect   = take_dbg | take_trap | take_return_from_interrupt_instr | take_debug_return_instr
                    | take_nmi | take_mi;

  // return source follows the in-progress flags
  assign return_from_interrupt_instr_nmi    = ~psw_r[EP_BIT] & psw_r[NP_BIT];
  assign return_from_interrupt_instr_plain  = ~psw_r[EP_BIT] & ~psw_r[NP_BIT];
  assign return_from_interrupt_instr_pc     = return_from_interrupt_instr_nmi ? nmi_pc_r  : exc_pc_r;
  assign return_from_interrupt_instr_psw    = return_from_interrupt_instr_nmi ? nmi_psw_r : exc_psw_r;
  assign trap_target = i_trap_vec[TRAP_SEL_BIT] ? TRAP_HI_VEC : TRAP_LO_VEC;

  // ---------------------------------------------------------------
  // status word: hardware events win over software loads
  // ---------------------------------------------------------------
  always_comb begin
    psw_nxt = psw_r;
    if (take_dbg) begin
      psw_nxt = psw_r | (32'h1 << NP_BIT) | (32'h1 << EP_BIT)
              | (32'h1 << ID_BIT);
    end else if (take_trap) begin
      psw_nxt = psw_r | (32'h1 << EP_BIT) | (32'h1 << ID_BIT);
    end else if (take_nmi) begin
      psw_nxt = psw_r | (32'h1 << NP_BIT) | (32'h1 << ID_BIT);
    end else if (take_mi) begin
      psw_nxt = psw_r | (32'h1 << ID_BIT);
    end else if (take_return_from_interrupt_instr) begin
      psw_nxt = return_from_interrupt_instr_psw;
    end else if (take_debug_return_instr) begin
      psw_nxt = dbg_psw_r;
    end else if (ok_instr & i_op_di) begin
      psw_nxt = psw_r | (32'h1 << ID_BIT);
    end else if (ok_instr & i_op_ei) begin
      psw_nxt = psw_r & ~(32'h1 << ID_BIT);
    end else if (ok_instr & i_op_load_system_reg_instr_psw) begin
      psw_nxt = i_load_system_reg_instr_data;
    end else if (bus_psw_wr) begin
      psw_nxt = psw_wr_val;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      psw_r <= PSW_RST;
    end else begin
      psw_r <= psw_nxt;
    end
  end

  // ---------------------------------------------------------------
  // save copies for software exceptions and maskable requests
  // ---------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      exc_pc_r  <= 32'h0;
      exc_psw_r <= 32'h0;
      cause_r   <= 32'h0;
    end else if (take_trap) begin
      exc_pc_r       <= i_pc;
      exc_psw_r      <= psw_r;
      cause_r[15:0]  <= TRAP_CODE_BASE + {11'h0, i_trap_vec};
    end else if (take_mi) begin
      exc_pc_r       <= i_pc;
      exc_psw_r      <= psw_r;
      cause_r[15:0]  <= i_mi_code;
    end else if (take_nmi) begin
      cause_r[31:16] <= i_nmi_code;
    end
  end

  // non-maskable copies
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      nmi_pc_r  <= 32'h0;
      nmi_psw_r <= 32'h0;
    end else if (take_nmi) begin
      nmi_pc_r  <= i_pc;
      nmi_psw_r <= psw_r;
    end
  end

  // debug copies and the window that guards them
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dbg_pc_r   <= 32'h0;
      dbg_psw_r  <= 32'h0;
      dbg_open_r <= 1'b0;
    end else if (take_dbg) begin
      dbg_pc_r   <= i_pc;
      dbg_psw_r  <= psw_r;
      dbg_open_r <= 1'b1;
    end else if (take_debug_return_instr) begin
      dbg_open_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // in-service levels
  // ---------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      in_service_priority_r <= 8'h00;
    end else if (take_mi) begin
      in_service_priority_r <= in_service_priority_r | (8'h01 << i_mi_prio);
    end else if (take_return_from_interrupt_instr & return_from_interrupt_instr_plain) begin
      in_service_priority_r <= in_service_priority_r & ~top_onehot;
    end
  end

  // ---------------------------------------------------------------
  // redirect and acknowledge outputs
  // ---------------------------------------------------------------
  always_comb begin
    pc_nxt = pc_target_r;
    if (take_dbg) begin
      pc_nxt = DBG_VEC;
    end else if (take_trap) begin
      pc_nxt = trap_target;
    end else if (take_return_from_interrupt_instr) begin
      pc_nxt = return_from_interrupt_instr_pc;
    end else if (take_debug_return_instr) begin
      pc_nxt = dbg_pc_r;
    end else if (take_nmi) begin
      pc_nxt = i_nmi_handler;
    end else if (take_mi) begin
      pc_nxt = i_mi_handler;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pc_load_r   <= 1'b0;
      pc_target_r <= 32'h0;
      nmi_ack_r   <= 1'b0;
      mi_ack_r    <= 1'b0;
    end else begin
      pc_load_r   <= redirect;
      pc_target_r <= pc_nxt;
      nmi_ack_r   <= take_nmi;
      mi_ack_r    <= take_mi;
    end
  end

  // ---------------------------------------------------------------
  // register slave: write path
  // ---------------------------------------------------------------
  // address and data are caught in any order, one write at a time
  assign wr_fire    = ~awready_r & ~wready_r & ~bvalid_r;
  assign bus_psw_wr = wr_fire & (awaddr_r == REG_PSW);
  assign wr_known   = (awaddr_r <= REG_IN_SERVICE_PRIORITY) & (awaddr_r[1:0] == 2'b00);

  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : g_lane
      assign psw_wr_val[8*b +: 8] = wstrb_r[b] ? wdata_r[8*b +: 8] : psw_r[8*b +: 8];
    end
  endgenerate

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      awready_r <= 1'b1;
      awaddr_r  <= '0;
    end else if (i_awvalid & awready_r) begin
      awready_r <= 1'b0;
      awaddr_r  <= i_awaddr;
    end else if (bvalid_r & i_bready) begin
      awready_r <= 1'b1;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wready_r <= 1'b1;
      wdata_r  <= 32'h0;
      wstrb_r  <= 4'h0;
    end else if (i_wvalid & wready_r) begin
      wready_r <= 1'b0;
      wdata_r  <= i_wdata;
      wstrb_r  <= i_wstrb;
    end else if (bvalid_r & i_bready) begin
      wready_r <= 1'b1;
    end
  end

  // only the status word takes writes; the copies are read only
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r  <= (awaddr_r == REG_PSW) ? RESP_OKAY :
                  (wr_known ? RESP_SLVERR : RESP_DECERR);
    end else if (bvalid_r & i_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // register slave: read path
  // ---------------------------------------------------------------
  always_comb begin
    rd_val  = 32'h0;
    rd_resp = RESP_OKAY;
    case (i_araddr)
      REG_PSW:     rd_val = psw_r;
      REG_EXC_PC:  rd_val = exc_pc_r;
      REG_EXC_PSW: rd_val = exc_psw_r;
      REG_CAUSE:   rd_val = cause_r;
      REG_NMI_PC:  rd_val = nmi_pc_r;
      REG_NMI_PSW: rd_val = nmi_psw_r;
      REG_DBG_PC: begin
        rd_val  = dbg_open_r ? dbg_pc_r : 32'h0;
        rd_resp = dbg_open_r ? RESP_OKAY : RESP_SLVERR;
      end
      REG_DBG_PSW: begin
        rd_val  = dbg_open_r ? dbg_psw_r : 32'h0;
        rd_resp = dbg_open_r ? RESP_OKAY : RESP_SLVERR;
      end
      REG_IN_SERVICE_PRIORITY:    rd_val = {24'h0, in_service_priority_r};
      default:     rd_resp = RESP_DECERR;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0;
      rresp_r   <= RESP_OKAY;
    end else if (i_arvalid & arready_r) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rdata_r   <= rd_val;
      rresp_r   <= rd_resp;
    end else if (rvalid_r & i_rready) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign o_pc_load   = pc_load_r;
  assign o_pc_target = pc_target_r;
  assign o_nmi_ack   = nmi_ack_r;
  assign o_mi_ack    = mi_ack_r;
  assign o_psw       = psw_r;
  assign o_in_service_priority      = in_service_priority_r;
  assign o_dbg_open  = dbg_open_r;
  assign o_awready   = awready_r;
  assign o_wready    = wready_r;
  assign o_bvalid    = bvalid_r;
  assign o_bresp     = bresp_r;
  assign o_arready   = arready_r;
  assign o_rvalid    = rvalid_r;
  assign o_rdata     = rdata_r;
  assign o_rresp     = rresp_r;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  sequence s_trap_taken;
    take_trap ##1 pc_load_r;
  endsequence

  sequence s_dbg_taken;
    take_dbg ##1 pc_load_r;
  endsequence

  a_mask_refused: assert property (
    mi_ack_r |-> !$past(psw_r[ID_BIT]))
    else $error("maskable request taken while disabled");

  a_mask_sets_id: assert property (
    take_mi |=> psw_r[ID_BIT] && mi_ack_r ##1 !mi_ack_r)
    else $error("maskable accept did not disable");

  a_trap_vector: assert property (
    s_trap_taken |-> pc_target_r ==
      ($past(i_trap_vec[TRAP_SEL_BIT]) ? TRAP_HI_VEC : TRAP_LO_VEC))
    else $error("trap handler address wrong");

  a_trap_saves: assert property (
    take_trap |=> exc_pc_r == $past(i_pc) && exc_psw_r == $past(psw_r)
      && psw_r[EP_BIT] && psw_r[ID_BIT])
    else $error("trap save or flags wrong");

  a_bad_op_trap: assert property (
    s_dbg_taken |-> pc_target_r == DBG_VEC && psw_r[NP_BIT]
      && psw_r[EP_BIT] && psw_r[ID_BIT] && dbg_pc_r == $past(i_pc))
    else $error("debug entry wrong");

  a_debug_return: assert property (
    take_debug_return_instr |=> pc_load_r && pc_target_r == $past(dbg_pc_r)
      && psw_r == $past(dbg_psw_r) && !dbg_open_r)
    else $error("debug return restore wrong");

  a_return_from_interrupt_instr_exc: assert property (
    take_return_from_interrupt_instr && psw_r[EP_BIT] |=> pc_target_r == $past(exc_pc_r)
      && psw_r == $past(exc_psw_r) && in_service_priority_r == $past(in_service_priority_r))
    else $error("exception return restore wrong");

  a_nmi_any_id: assert property (
    i_nmi_req && !i_instr_valid && !nmi_ack_r |=> nmi_ack_r && psw_r[NP_BIT])
    else $error("non-maskable request not taken");

  a_pending_taken: assert property (
    i_mi_req && !psw_r[ID_BIT] && !i_instr_valid && !i_nmi_req
      && !prio_blocked |=> mi_ack_r)
    else $error("pending request not taken");

  a_dbg_closed: assert property (
    i_arvalid && arready_r && !dbg_open_r && i_araddr == REG_DBG_PC
      |=> rvalid_r && rresp_r == RESP_SLVERR && rdata_r == 32'h0)
    else $error("debug copy read outside window");

endmodule

// file: verif/tex_decode_model.sv
// decode pipeline and interrupt requester facing the trap unit
`timescale 1ns/100ps
module tex_decode_model (
  input  wire logic        i_clock,
  input  wire logic        i_mi_ack,
  input  wire logic        i_nmi_ack,
  output logic             o_valid,
  output logic [6:0]       o_op,
  output logic [31:0]      o_instr,
  output logic [31:0]      o_pc,
  output logic             o_mi_req,
  output logic             o_nmi_req
);
  initial {o_valid, o_op, o_instr, o_pc, o_mi_req, o_nmi_req} = '0;
  // requests are levels, dropped only once acknowledged
  always @(posedge i_clock) begin
    if (i_mi_ack) o_mi_req <= 1'b0;
    if (i_nmi_ack) o_nmi_req <= 1'b0;
  end
  // one executed instruction, reserved encodings only on demand
  task automatic issue(input logic [6:0] op, input logic [31:0] ins, input logic [31:0] pc);
    @(posedge i_clock);
    {o_valid, o_op, o_instr, o_pc} <= {1'b1, op, ins, pc};
    @(posedge i_clock);
    {o_valid, o_op, o_instr} <= {8'h00, ~ins}; // word is inverted once valid drops
  endtask
  // raise a request at the next edge
  task automatic raise(input logic nmi);
    @(posedge i_clock);
    if (nmi) o_nmi_req <= 1'b1;
    else o_mi_req <= 1'b1;
  endtask
endmodule

// file: verif/tb_top.sv
// self-checking bench for the trap and exception unit
`timescale 1ns/100ps
module tb_top;
  import tex_pkg::*;
  logic        i_clock = 0, i_rst_n = 0, i_awvalid = 0, i_wvalid = 0, i_bready = 0;
  logic        i_arvalid = 0, i_rready = 0;
  logic [3:0]  i_wstrb = 4'hf;
  logic [4:0]  i_trap_vec = '0, v;
  logic [2:0]  i_mi_prio = 3'h3;
  logic [7:0]  i_awaddr = '0, i_araddr = '0, o_in_service_priority;
  logic [15:0] i_nmi_code = '0, i_mi_code = '0;
  logic [31:0] i_wdata = '0, i_load_system_reg_instr_data = '0, i_nmi_handler = '0, i_mi_handler = '0;
  logic [31:0] i_instr, i_pc, o_pc_target, o_psw, o_rdata, pc, old, h, psw_m;
  logic        i_instr_valid, i_nmi_req, i_mi_req, o_pc_load, o_nmi_ack, o_mi_ack, o_dbg_open;
  logic        i_op_di, i_op_ei, i_op_return_from_interrupt_instr, i_op_trap, i_op_debug_break_instr, i_op_debug_return_instr, i_op_load_system_reg_instr_psw;
  logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [1:0]  o_bresp, o_rresp;
  logic [6:0]  op7;
  logic [19:0] vt = {5'h00, 5'h0f, 5'h10, 5'h1f};
  integer      seed = 32'hb0f4ad12, fail_count = 0, comparisons = 0;
  integer      mi_acks = 0, nmi_acks = 0;
  logic [63:0] ev_q[$];
  logic [33:0] rd_q[$];
  logic [1:0]  b_q[$];

  assign {i_op_di, i_op_ei, i_op_return_from_interrupt_instr, i_op_trap, i_op_debug_break_instr, i_op_debug_return_instr, i_op_load_system_reg_instr_psw} = op7;
  tex_unit dut (.i_clock, .i_rst_n, .i_instr_valid, .i_instr, .i_pc, .i_op_di, .i_op_ei,
    .i_op_return_from_interrupt_instr, .i_op_trap, .i_trap_vec, .i_op_debug_break_instr, .i_op_debug_return_instr, .i_op_load_system_reg_instr_psw,
    .i_load_system_reg_instr_data, .i_nmi_req, .i_nmi_handler, .i_nmi_code, .i_mi_req, .i_mi_prio,
    .i_mi_handler, .i_mi_code, .o_pc_load, .o_pc_target, .o_nmi_ack, .o_mi_ack, .o_psw,
    .o_in_service_priority, .o_dbg_open, .i_awvalid, .o_awready, .i_awaddr, .i_wvalid, .o_wready, .i_wdata,
    .i_wstrb, .o_bvalid, .i_bready, .o_bresp, .i_arvalid, .o_arready, .i_araddr, .o_rvalid,
    .i_rready, .o_rdata, .o_rresp);
  tex_decode_model u_dec (.i_clock, .i_mi_ack(o_mi_ack), .i_nmi_ack(o_nmi_ack),
    .o_valid(i_instr_valid), .o_op(op7), .o_instr(i_instr), .o_pc(i_pc),
    .o_mi_req(i_mi_req), .o_nmi_req(i_nmi_req));

  initial forever #20 i_clock = ~i_clock;
  // ------------------------------------------------------------
  // checking
  // ------------------------------------------------------------
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic end_of_test;
    if (fail_count == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // an answer with no note queued compares against unknown and fails
  // outputs are unknown before the first reset edge, so watch only once out of reset
  always @(posedge i_clock) if (i_rst_n) begin
    if (o_pc_load !== 1'b0) chk({o_pc_target, o_psw}, ev_q.size() ? ev_q.pop_front() : 'x);
    if (o_bvalid === 1'b1 && i_bready) chk(o_bresp, b_q.size() ? b_q.pop_front() : 'x);
    if (o_rvalid === 1'b1 && i_rready)
      chk({o_rresp, o_rdata}, rd_q.size() ? rd_q.pop_front() : 'x);
    if (o_mi_ack !== 1'b0) mi_acks++;
    if (o_nmi_ack !== 1'b0) nmi_acks++;
  end
  // ------------------------------------------------------------
  // bus and instruction drivers
  // ------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    b_q.push_back(r);
    @(posedge i_clock);
    {i_awaddr, i_wdata, i_awvalid, i_wvalid, i_bready} <= {a, d, 3'b111};
    for (n = 0; n < 40 && o_bvalid !== 1'b1; n++) begin
      @(posedge i_clock);
      if (o_awready) i_awvalid <= 1'b0;
      if (o_wready) i_wvalid <= 1'b0;
    end
    i_bready <= 1'b0;
    if (n == 40) fail_count++;
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    int n;
    rd_q.push_back(e);
    @(posedge i_clock);
    {i_araddr, i_arvalid, i_rready} <= {a, 2'b11};
    for (n = 0; n < 40 && o_rvalid !== 1'b1; n++) begin
      @(posedge i_clock);
      if (o_arready) i_arvalid <= 1'b0;
    end
    i_rready <= 1'b0;
    if (n == 40) fail_count++;
  endtask
  task automatic ex(input logic [6:0] o, input logic [31:0] ins);
    pc = $random(seed);
    u_dec.issue(o, ins, pc);
  endtask
  // hang guard at 2500 cycles, far beyond the fewer than two hundred cycles needed
  initial begin
    #100000;
    fail_count++;
    end_of_test();
  end
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    repeat (16) @(posedge i_clock);
    i_rst_n <= 1'b1;
    chk(o_psw, PSW_RST);
    h = $random(seed);
    i_mi_handler <= h;
    u_dec.raise(1'b0);
    repeat (8) @(posedge i_clock);
    ev_q.push_back({h, 32'h20});
    ex(7'h20, 0);
    old = pc;
    rd(REG_IN_SERVICE_PRIORITY, {RESP_OKAY, 32'h8});
    chk(o_in_service_priority, 8'h08);
    ev_q.push_back({old, 32'h0});
    ex(7'h10, 0);
    rd(REG_IN_SERVICE_PRIORITY, {RESP_OKAY, 32'h0});
    chk(o_in_service_priority, 8'h00);
    for (int i = 0; i < 6; i++) begin
      v = (i < 4) ? vt[i*5 +: 5] : 5'($random(seed));
      psw_m = i[0] ? 32'h20 : 32'h0;
      ex(i[0] ? 7'h40 : 7'h20, 0);
      i_trap_vec <= v;
      ev_q.push_back({v[4] ? TRAP_HI_VEC : TRAP_LO_VEC, psw_m | 32'h60});
      ex(7'h08, 0);
      old = pc;
      rd(REG_CAUSE, {RESP_OKAY, 16'h0, {11'h0, v} + 16'h40});
      rd(REG_EXC_PC, {RESP_OKAY, old});
      // handler disturbs the in-progress flags, then puts them back before return
      if (i == 5) begin
        i_load_system_reg_instr_data <= 32'h20;
        ex(7'h01, 0);
        i_load_system_reg_instr_data <= 32'h60;
        ex(7'h01, 0);
      end
      ev_q.push_back({old, psw_m});
      ex(7'h10, 0);
    end
    ex(7'h40, 0);
    old = pc;
    h = $random(seed);
    {i_nmi_handler, i_nmi_code} <= {h, 16'h5a3c};
    ev_q.push_back({h, 32'ha0});
    u_dec.raise(1'b1);
    ev_q.push_back({old, 32'h20});
    ex(7'h10, 0);
    rd(REG_CAUSE, {RESP_OKAY, 16'h5a3c, {11'h0, v} + 16'h40});
    for (int k = 0; k < 3; k++) begin
      ev_q.push_back({DBG_VEC, 32'he0});
      ex(k == 2 ? 7'h04 : 7'h00, k == 2 ? 32'h0 : (k ? 32'h0780_07e0 : 32'h0380_07e0));
      old = pc;
      rd(REG_DBG_PC, {RESP_OKAY, old});
      chk(o_dbg_open, 1'b1);
      ev_q.push_back({old, 32'h20});
      ex(7'h02, 0);
    end
    rd(REG_DBG_PC, {RESP_SLVERR, 32'h0});
    chk(o_dbg_open, 1'b0);
    ex(7'h00, 32'h0300_07e0);
    ex(7'h00, 32'h0381_07e0);
    i_load_system_reg_instr_data <= 32'h40;
    ex(7'h01, 0);
    rd(REG_PSW, {RESP_OKAY, 32'h40});
    wr(REG_PSW, 32'h20, RESP_OKAY);
    rd(REG_PSW, {RESP_OKAY, 32'h20});
    // low byte strobed off keeps the disable flag as it was
    i_wstrb <= 4'he;
    wr(REG_PSW, 32'h1234_5600, RESP_OKAY);
    rd(REG_PSW, {RESP_OKAY, 32'h1234_5620});
    wr(REG_EXC_PC, 32'h1, RESP_SLVERR);
    rd(8'h24, {RESP_DECERR, 32'h0});
    repeat (4) @(posedge i_clock);
    chk(mi_acks, 1);
    chk(nmi_acks, 1);
    end_of_test();
  end
endmodule
